// File: design/ifr_consts.svh
`ifndef IFR_CONSTS_SVH
`define IFR_CONSTS_SVH

// byte offsets of the register map
`define IFR_OFF_ENABLE      5'h08
`define IFR_OFF_ROUTE       5'h0C
`define IFR_OFF_PENDING     5'h10
`define IFR_OFF_TEST_SEL    5'h18
`define IFR_OFF_TEST_SRC    5'h1C

// field positions and source count
`define IFR_SWI_BIT         23
`define IFR_TEST_SEL_BIT    0
`define IFR_NUM_SRC         24

// reset values
`define IFR_RST_ENABLE      24'h000000
`define IFR_RST_ROUTE       24'h000000
`define IFR_RST_PENDING     24'h000000
`define IFR_RST_TEST_SEL    1'h0
`define IFR_RST_TEST_SRC    24'h000000

// synchroniser depth on the request inputs
`define IFR_SYNC_STAGES     2

`endif

// File: design/ifr_pkg.sv
package ifr_pkg;

    typedef enum logic {
        IFR_ST_IDLE,
        IFR_ST_HELD
    } ifr_bus_state_t;

    typedef logic [23:0] ifr_word_t;
    typedef logic [2:0]  ifr_addr_t;

endpackage

// File: design/ifr_sync.sv
`timescale 1ns/1ps
`include "ifr_consts.svh"

module ifr_sync #(
    parameter int WIDTH = `IFR_NUM_SRC
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_resetn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    // one two-stage chain per bit; the first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            logic meta_reg;
            logic stable_reg;
            always_ff @(posedge i_sys_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    meta_reg   <= 1'b0;
                    stable_reg <= 1'b0;
                end else begin
                    meta_reg   <= i_async[g];
                    stable_reg <= meta_reg;
                end
            end
            assign o_sync[g] = stable_reg;
        end
    endgenerate

endmodule

// File: design/ifr_top.sv
`timescale 1ns/1ps
`include "ifr_consts.svh"

module ifr_top #(
    parameter int NUM_SRC = `IFR_NUM_SRC,
    parameter int SWI_BIT = `IFR_SWI_BIT
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_periph_sel,
    input  wire logic                  i_periph_strobe,
    input  wire logic                  i_periph_write,
    input  wire ifr_pkg::ifr_addr_t    i_periph_addr,
    input  wire ifr_pkg::ifr_word_t    i_periph_data,
    output ifr_pkg::ifr_word_t         o_periph_data,
    output logic                       o_periph_data_oe,
    input  wire logic [NUM_SRC-1:0]    i_int_request,
    output logic                       o_normal_request_n,
    output logic                       o_fast_request_n
);
    import ifr_pkg::*;

    localparam logic [4:0] OFF_ENABLE   = `IFR_OFF_ENABLE;
    localparam logic [4:0] OFF_ROUTE    = `IFR_OFF_ROUTE;
    localparam logic [4:0] OFF_PENDING  = `IFR_OFF_PENDING;
    localparam logic [4:0] OFF_TEST_SEL = `IFR_OFF_TEST_SEL;
    localparam logic [4:0] OFF_TEST_SRC = `IFR_OFF_TEST_SRC;

    // registers, and the combinational bus_state_next
    logic [NUM_SRC-1:0] source_enable_reg;
    logic [NUM_SRC-1:0] route_select_reg;
    logic [NUM_SRC-1:0] pending_view_reg;
    logic               test_input_select_reg;
    logic [NUM_SRC-1:0] test_source_levels_reg;
    ifr_bus_state_t     bus_state_reg;
    ifr_bus_state_t     bus_state_next;
    ifr_word_t          rdata_reg;
    logic               rdata_oe_reg;
    logic               normal_req_n_reg;
    logic               fast_req_n_reg;

    // combinational
    logic [NUM_SRC-1:0] ext_levels;
    logic [NUM_SRC-1:0] raw_levels;
    logic [NUM_SRC-1:0] src_levels;
    logic [NUM_SRC-1:0] pending_next;
    logic               normal_req_n_next;
    logic               fast_req_n_next;
    logic               access;
    logic               wr_take;
    logic               rd_active;
    logic               sel_enable;
    logic               sel_route;
    logic               sel_pending;
    logic               sel_test_sel;
    logic               sel_test_src;
    ifr_word_t          rdata_next;

    // request inputs come from other logic that may not share this clock
    ifr_sync #(
        .WIDTH (NUM_SRC)
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_async   (i_int_request),
        .o_sync    (ext_levels)
    );

    // source selection and gating
    assign raw_levels   = test_input_select_reg ? test_source_levels_reg
                                                : ext_levels;
    // software source stays active in both modes, so only its enable matters
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g = g + 1) begin : g_src
            if (g == SWI_BIT) begin : g_swi
                assign src_levels[g] = 1'b1;
            end else begin : g_ext
                assign src_levels[g] = raw_levels[g];
            end
        end
    endgenerate

    assign pending_next      = src_levels & source_enable_reg;
    // plain wired-or per output: no ordering between sources
    assign normal_req_n_next = ~|(pending_next & ~route_select_reg);
    assign fast_req_n_next   = ~|(pending_next & route_select_reg);

    // bus decode
    assign access       = i_periph_sel & i_periph_strobe;
    assign wr_take      = access & i_periph_write & (bus_state_reg == IFR_ST_IDLE);
    assign rd_active    = access & ~i_periph_write;
    assign sel_enable   = (i_periph_addr == OFF_ENABLE[4:2]);
    assign sel_route    = (i_periph_addr == OFF_ROUTE[4:2]);
    assign sel_pending  = (i_periph_addr == OFF_PENDING[4:2]);
    assign sel_test_sel = (i_periph_addr == OFF_TEST_SEL[4:2]);
    assign sel_test_src = (i_periph_addr == OFF_TEST_SRC[4:2]);

    // write-only and unmapped words read back as zero
    assign rdata_next = sel_enable  ? ifr_word_t'(source_enable_reg) :
                        sel_route   ? ifr_word_t'(route_select_reg)  :
                        sel_pending ? ifr_word_t'(pending_view_reg)  :
                                      24'h000000;

    // one write per strobe: a long strobe must not repeat the store
    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            IFR_ST_IDLE: begin
                if (access) begin
                    bus_state_next = IFR_ST_HELD;
                end
            end
            IFR_ST_HELD: begin
                if (!access) begin
                    bus_state_next = IFR_ST_IDLE;
                end
            end
            default: begin
                bus_state_next = IFR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bus_state_reg <= IFR_ST_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            source_enable_reg <= `IFR_RST_ENABLE;
        end else if (wr_take && sel_enable) begin
            source_enable_reg <= i_periph_data[NUM_SRC-1:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            route_select_reg <= `IFR_RST_ROUTE;
        end else if (wr_take && sel_route) begin
            route_select_reg <= i_periph_data[NUM_SRC-1:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            test_input_select_reg <= `IFR_RST_TEST_SEL;
        end else if (wr_take && sel_test_sel) begin
            test_input_select_reg <= i_periph_data[`IFR_TEST_SEL_BIT];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            test_source_levels_reg <= `IFR_RST_TEST_SRC;
        end else if (wr_take && sel_test_src) begin
            test_source_levels_reg <= i_periph_data[NUM_SRC-1:0];
        end
    end

    // status and request outputs from the same cycle's view
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pending_view_reg <= `IFR_RST_PENDING;
            normal_req_n_reg <= 1'b1;
            fast_req_n_reg   <= 1'b1;
        end else begin
            pending_view_reg <= pending_next;
            normal_req_n_reg <= normal_req_n_next;
            fast_req_n_reg   <= fast_req_n_next;
        end
    end

    // read data refreshed every cycle of a read so status is live
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_reg    <= 24'h000000;
            rdata_oe_reg <= 1'b0;
        end else begin
            rdata_oe_reg <= rd_active;
            if (rd_active) begin
                rdata_reg <= rdata_next;
            end else begin
                rdata_reg <= 24'h000000;
            end
        end
    end

    assign o_periph_data      = rdata_reg;
    assign o_periph_data_oe   = rdata_oe_reg;
    assign o_normal_request_n = normal_req_n_reg;
    assign o_fast_request_n   = fast_req_n_reg;

endmodule

// File: dv/ifr_top_checker.sv
`timescale 1ns/1ps
module ifr_top_checker (
    input wire logic               i_sys_clk,
    input wire logic               i_resetn,
    input wire logic               i_periph_sel,
    input wire logic               i_periph_strobe,
    input wire logic               i_periph_write,
    input wire ifr_pkg::ifr_addr_t i_periph_addr,
    input wire ifr_pkg::ifr_word_t o_periph_data,
    input wire logic               o_periph_data_oe,
    input wire logic               o_normal_request_n,
    input wire logic               o_fast_request_n
);
    import ifr_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    wire rd      = i_periph_sel && i_periph_strobe && !i_periph_write;
    wire any_req = !o_normal_request_n || !o_fast_request_n;
    // slack of a cycle: read data is registered one edge after the status and request flops
    property p_rd_oe; rd |=> o_periph_data_oe; endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("read not answered");
    property p_oe_drop; !rd |=> !o_periph_data_oe; endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("bus held");
    property p_idle_zero; !o_periph_data_oe |-> o_periph_data == 24'h000000; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("idle data");
    property p_hole_zero;
        rd && i_periph_addr inside {3'h0, 3'h1, 3'h5, 3'h6, 3'h7} |=> o_periph_data == 24'h000000;
    endproperty
    a_hole_zero: assert property (p_hole_zero) else $error("hole read");
    property p_rst_quiet; $rose(i_resetn) |-> o_normal_request_n && o_fast_request_n; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("request at reset");
    property p_stat_req;
        o_periph_data_oe && $past(i_periph_addr) == 3'h4 && o_periph_data != 24'h000000
            |-> ##[0:1] any_req;
    endproperty
    a_stat_req: assert property (p_stat_req) else $error("pending, no request");
    property p_en_off;
        o_periph_data_oe && $past(i_periph_addr) == 3'h2 && o_periph_data == 24'h000000
            |-> ##2 !any_req;
    endproperty
    a_en_off: assert property (p_en_off) else $error("request while masked");
    property p_swi;
        o_periph_data_oe && $past(i_periph_addr) == 3'h2 && o_periph_data[23] |-> ##2 any_req;
    endproperty
    a_swi: assert property (p_swi) else $error("software request missing");
endmodule

bind ifr_top ifr_top_checker u_chk (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_periph_sel(i_periph_sel),
    .i_periph_strobe(i_periph_strobe), .i_periph_write(i_periph_write),
    .i_periph_addr(i_periph_addr), .o_periph_data(o_periph_data),
    .o_periph_data_oe(o_periph_data_oe), .o_normal_request_n(o_normal_request_n),
    .o_fast_request_n(o_fast_request_n)
);

// File: dv/ifr_cpu_model.sv
`timescale 1ns/1ps
module ifr_cpu_model (
    input  wire logic i_sys_clk,
    input  wire logic i_normal_request_n,
    input  wire logic i_fast_request_n,
    output logic      o_normal_seen,
    output logic      o_fast_seen
);
    // core samples levels each clock; it keeps no memory of edges
    always_ff @(posedge i_sys_clk) begin
        o_normal_seen <= !i_normal_request_n;
        o_fast_seen   <= !i_fast_request_n;
    end
endmodule

// File: dv/ifr_top_tb.sv
`timescale 1ns/1ps
module ifr_top_tb;
    import ifr_pkg::*;
    logic      sys_clk  = 1'b0;
    logic      resetn   = 1'b0;
    logic      sel      = 1'b0;
    logic      stb      = 1'b0;
    logic      wr       = 1'b0;
    ifr_addr_t addr     = 3'h0;
    ifr_word_t wdata    = 24'h000000;
    ifr_word_t irq_in   = 24'h000000;
    ifr_word_t rdata;
    logic      rd_oe;
    logic      nreq_n;
    logic      freq_n;
    logic      normal_seen;
    logic      fast_seen;
    int        failures = 0;
    int        checks   = 0;
    always #50 sys_clk = ~sys_clk;
    ifr_top DUT (
        .i_sys_clk(sys_clk), .i_resetn(resetn), .i_periph_sel(sel), .i_periph_strobe(stb),
        .i_periph_write(wr), .i_periph_addr(addr), .i_periph_data(wdata),
        .o_periph_data(rdata), .o_periph_data_oe(rd_oe), .i_int_request(irq_in),
        .o_normal_request_n(nreq_n), .o_fast_request_n(freq_n)
    );
    ifr_cpu_model u_cpu (
        .i_sys_clk(sys_clk), .i_normal_request_n(nreq_n), .i_fast_request_n(freq_n),
        .o_normal_seen(normal_seen), .o_fast_seen(fast_seen)
    );
    task automatic test_done;
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input ifr_word_t got, input ifr_word_t exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input ifr_addr_t a, input ifr_word_t d);
        @(posedge sys_clk);
        sel <= 1'b1;
        stb <= 1'b1;
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        sel <= 1'b0;
        stb <= 1'b0;
        wdata <= ~d; // released bus must not keep the old value
    endtask
    task automatic rreg(input ifr_addr_t a, input ifr_word_t e);
        @(posedge sys_clk);
        sel <= 1'b1;
        stb <= 1'b1;
        wr <= 1'b0;
        addr <= a;
        @(posedge sys_clk);
        sel <= 1'b0;
        stb <= 1'b0;
        #1;
        chk({23'h0, rd_oe}, 24'h000001);
        chk(rdata, e);
    endtask
    task automatic step(input bit tm, input ifr_word_t en, rt, src, st, input logic [1:0] rq);
        wreg(3'h2, en);
        wreg(3'h3, rt);
        if (tm) begin
            wreg(3'h7, src);
        end else begin
            @(posedge sys_clk);
            irq_in <= src;
        end
        repeat (6) @(posedge sys_clk);
        rreg(3'h4, st);
        chk({22'h0, normal_seen, fast_seen}, {22'h0, rq});
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        rreg(3'h2, 24'h000000);
        rreg(3'h3, 24'h000000);
        wreg(3'h0, 24'hFFFFFF);
        wreg(3'h4, 24'hFFFFFF);
        rreg(3'h0, 24'h000000);
        rreg(3'h4, 24'h000000);
        rreg(3'h6, 24'h000000);
        rreg(3'h7, 24'h000000);
        wreg(3'h3, 24'hA5A5A5);
        rreg(3'h3, 24'hA5A5A5);
        step(0, 24'h000003, 24'h000002, 24'h000001, 24'h000001, 2'b10);
        step(0, 24'h000003, 24'h000002, 24'h000002, 24'h000002, 2'b01);
        step(0, 24'h000003, 24'h000002, 24'h000007, 24'h000003, 2'b11);
        step(0, 24'h000000, 24'h000002, 24'h000007, 24'h000000, 2'b00);
        step(0, 24'h800000, 24'h000000, 24'h000000, 24'h800000, 2'b10);
        step(0, 24'h800000, 24'h800000, 24'h800000, 24'h800000, 2'b01);
        step(0, 24'h7FFFFF, 24'h000000, 24'h800000, 24'h000000, 2'b00);
        step(0, 24'hFFFFFF, 24'h000001, 24'h000001, 24'h800001, 2'b11);
        rreg(3'h2, 24'hFFFFFF);
        wreg(3'h6, 24'h000001);
        step(1, 24'h000010, 24'h000010, 24'h000010, 24'h000010, 2'b01);
        @(posedge sys_clk);
        irq_in <= 24'h00000F;
        step(1, 24'h00000F, 24'h000000, 24'h000000, 24'h000000, 2'b00);
        wreg(3'h6, 24'h000000);
        step(0, 24'h00000F, 24'h000000, 24'h00000F, 24'h00000F, 2'b10);
        test_done();
    end
endmodule
